/* File: src/nic_controller.sv */
`timescale 1ns/1ns
// Operation
// R1: sources 48-54 map codes 0380H-03E0H, handler equals code
// R2: lower default number wins simultaneous maskables of equal level
// R3: simultaneous watchdog and pin: pin discarded
// R4: non-maskable ignores disable, beats maskables
// R5: pin edge: rise, fall, both, off
// R6: watchdog request only when mode is 01
// R7: pin request during pin service waits for return
// R8: watchdog waits while active flag set
// R9: non-maskable entry saves state, sets flags, vectors
// R10: return with EP0 NP1 restores non-maskable state
// R11: software resets after watchdog service, no return
// R12: active flag bit 7 blocks non-maskables; reset 20H
// R13: 55 sources, each with its own mask
// R14: eight programmable levels, default order breaks ties
// R15: maskable acceptance sets disable flag
// R16: only strictly higher level may nest
// R17: software saves maskable state before nesting
// R18: maskable entry saves state, code, vectors
// R19: masked or blocked requests stay pending
// R20: return with EP0 NP0 restores maskable state
// R21: abandoned instruction: saved PC points at it
// R22: illegal opcode saves instruction address plus 4
// R23: control register: flag7 mask6 level2-0, reset 47H
// R24: request flag cleared on acceptance
// R25: pin synchronised before edge detection
module nic_controller import nic_pkg::*; #(
    parameter int N = NUM_SRC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // non-maskable sources
    input wire logic nmi_pin,
    input wire logic [1:0] nmi_edge_sel,
    input wire logic watchdog_overflow_nmi,
    input wire logic [1:0] watchdog_mode,
    // maskable sources
    input wire logic [N-1:0] irq_src,
    // control register port
    input wire logic ic_wr,
    input wire logic [5:0] ic_addr,
    input wire logic [7:0] ic_wdata,
    output logic [7:0] ic_rdata_q,
    // core
    input wire logic [31:0] following_pc,
    input wire logic [31:0] cur_pc,
    input wire logic insn_abandon,
    input wire logic illegal_op,
    input wire logic return_from_trap,
    input wire logic unmask_all_instruction,
    input wire logic mask_all_instruction,
    input wire logic system_reg_load,
    input wire logic [2:0] sreg_sel,
    input wire logic [31:0] sreg_wdata,
    // exception entry
    output logic jump_q,
    output logic [31:0] jump_addr_q,
    output logic [31:0] program_status_word_q,
    output logic [31:0] nmi_saved_pc_q,
    output logic [31:0] nmi_saved_status_q,
    output logic [31:0] irq_saved_pc_q,
    output logic [31:0] irq_saved_status_q,
    output logic [31:0] exception_cause_register_q
);
    nic_arb_if #(.N(N)) arb_if ();

    logic pin_req;
    logic [N-1:0] flag_q;
    logic [N-1:0] mask_q;
    logic [N-1:0][2:0] prio_q;
    logic [7:0] in_service_q;
    logic pin_pend_q;
    logic wdt_pend_q;
    logic pin_svc_q;
    logic wdt_req;
    logic np;
    logic ep;
    logic id;
    logic [3:0] top_lvl;
    logic take_wdt;
    logic take_pin;
    logic take_irq;
    logic take_ill;
    logic ret_nmi;
    logic ret_irq;
    logic [31:0] restored_pc;
    logic [15:0] irq_code;

    // lowest in-service level, 8 when idle
    function automatic logic [3:0] lowest_set(input logic [7:0] v);
        lowest_set = 4'h8;
        for (int k = 7; k >= 0; k--) begin
            if (v[k]) begin
                lowest_set = 4'(k);
            end
        end
    endfunction : lowest_set

    nic_edge_detect u_edge (
        .clk_sys(clk_sys),
        .rst(rst),
        .pin(nmi_pin),
        .edge_sel(nmi_edge_sel),
        .req_q(pin_req)
    );

    nic_arbiter #(.N(N)) u_arb (
        .a(arb_if.arb)
    );

    assign arb_if.req = flag_q;
    assign arb_if.mask = mask_q; // [R13] [R19]
    assign arb_if.prio = prio_q;

    assign np = program_status_word_q[PSW_NP_BIT];
    assign ep = program_status_word_q[PSW_EP_BIT];
    assign id = program_status_word_q[PSW_ID_BIT];
    assign wdt_req = watchdog_overflow_nmi && watchdog_mode == WDT_NMI_MODE; // [R6]
    assign top_lvl = lowest_set(in_service_q);

    // acceptance decisions
    assign ret_nmi = return_from_trap && !ep && np; // [R10]
    assign ret_irq = return_from_trap && !ep && !np; // [R20]
    assign take_wdt = !return_from_trap && wdt_pend_q && !np; // [R4] [R8] [R12]
    assign take_pin = !return_from_trap && !take_wdt && pin_pend_q && !np && !pin_svc_q; // [R7] [R12]
    assign take_irq = !return_from_trap && !take_wdt && !take_pin && arb_if.win_valid && !id && !np
        && {1'b0, arb_if.win_lvl} < top_lvl; // [R4] [R15] [R16] [R19]
    assign take_ill = !return_from_trap && !take_wdt && !take_pin && !take_irq && illegal_op;

    assign restored_pc = insn_abandon ? cur_pc : following_pc; // [R21]
    assign irq_code = 16'(IRQ_CODE_BASE + IRQ_CODE_STEP * 16'(arb_if.win_idx)); // [R1]

    // pending non-maskable requests
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wdt_pend_q <= 1'b0;
            pin_pend_q <= 1'b0;
        end else begin
            wdt_pend_q <= wdt_req | (wdt_pend_q & ~take_wdt);
            if (wdt_req && pin_req) begin
                pin_pend_q <= pin_pend_q & ~take_pin; // [R3]
            end else begin
                pin_pend_q <= pin_req | (pin_pend_q & ~take_pin);
            end
        end
    end

    // pin service tracking
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pin_svc_q <= 1'b0;
        end else if (take_pin) begin
            pin_svc_q <= 1'b1;
        end else if (ret_nmi) begin
            pin_svc_q <= 1'b0; // [R7]
        end
    end

    // per-source control registers
    for (genvar i = 0; i < N; i++) begin : g_src
        logic hit;
        assign hit = ic_wr && ic_addr == 6'(i);
        always_ff @(posedge clk_sys) begin
            if (rst) begin
                flag_q[i] <= IC_RESET[IC_FLAG_BIT]; // [R23]
                mask_q[i] <= IC_RESET[IC_MASK_BIT];
                prio_q[i] <= IC_RESET[2:0];
            end else begin
                if (irq_src[i]) begin
                    flag_q[i] <= 1'b1;
                end else if (take_irq && arb_if.win_idx == 6'(i)) begin
                    flag_q[i] <= 1'b0; // [R24]
                end else if (hit) begin
                    flag_q[i] <= ic_wdata[IC_FLAG_BIT];
                end
                if (hit) begin
                    mask_q[i] <= ic_wdata[IC_MASK_BIT]; // [R23]
                    prio_q[i] <= ic_wdata[2:0];
                end
            end
        end
    end

    // control register read
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ic_rdata_q <= 8'h00;
        end else if (int'(ic_addr) < N) begin
            ic_rdata_q <= {flag_q[ic_addr], mask_q[ic_addr], 3'h0, prio_q[ic_addr]};
        end else begin
            ic_rdata_q <= 8'h00;
        end
    end

    // in-service levels for nesting
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            in_service_q <= 8'h00;
        end else if (take_irq) begin
            in_service_q[arb_if.win_lvl] <= 1'b1; // [R16]
        end else if (ret_irq && top_lvl != 4'h8) begin
            in_service_q[top_lvl[2:0]] <= 1'b0;
        end
    end

    // status word
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            program_status_word_q <= PSW_RESET; // [R12]
        end else if (ret_nmi) begin
            program_status_word_q <= nmi_saved_status_q; // [R10]
        end else if (ret_irq || (return_from_trap && ep)) begin
            program_status_word_q <= irq_saved_status_q; // [R20]
        end else if (take_wdt || take_pin) begin
            program_status_word_q[PSW_NP_BIT] <= 1'b1; // [R9] [R12]
            program_status_word_q[PSW_ID_BIT] <= 1'b1;
            program_status_word_q[PSW_EP_BIT] <= 1'b0;
        end else if (take_irq) begin
            program_status_word_q[PSW_ID_BIT] <= 1'b1; // [R15] [R18]
            program_status_word_q[PSW_EP_BIT] <= 1'b0;
        end else if (take_ill) begin
            program_status_word_q[PSW_ID_BIT] <= 1'b1;
            program_status_word_q[PSW_EP_BIT] <= 1'b1;
        end else if (system_reg_load && sreg_sel == SREG_PSW) begin
            program_status_word_q <= sreg_wdata; // [R19]
        end else if (unmask_all_instruction) begin
            program_status_word_q[PSW_ID_BIT] <= 1'b0;
        end else if (mask_all_instruction) begin
            program_status_word_q[PSW_ID_BIT] <= 1'b1;
        end
    end

    // non-maskable save registers and cause
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            nmi_saved_pc_q <= 32'h0000_0000;
            nmi_saved_status_q <= 32'h0000_0000;
            exception_cause_register_q[31:16] <= 16'h0000;
        end else if (take_wdt || take_pin) begin
            nmi_saved_pc_q <= restored_pc; // [R9]
            nmi_saved_status_q <= program_status_word_q;
            exception_cause_register_q[31:16] <= take_wdt ? NMI_WDT_CODE : NMI_PIN_CODE;
        end else if (system_reg_load && sreg_sel == SREG_NMI_PC) begin
            nmi_saved_pc_q <= sreg_wdata;
        end else if (system_reg_load && sreg_sel == SREG_NMI_PSW) begin
            nmi_saved_status_q <= sreg_wdata;
        end
    end

    // maskable save registers and cause
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_saved_pc_q <= 32'h0000_0000;
            irq_saved_status_q <= 32'h0000_0000;
            exception_cause_register_q[15:0] <= 16'h0000;
        end else if (take_irq) begin
            irq_saved_pc_q <= restored_pc; // [R18] [R21]
            irq_saved_status_q <= program_status_word_q;
            exception_cause_register_q[15:0] <= irq_code;
        end else if (take_ill) begin
            irq_saved_pc_q <= cur_pc + ILL_PC_ADJ; // [R22]
            irq_saved_status_q <= program_status_word_q;
            exception_cause_register_q[15:0] <= ILL_CODE;
        end else if (system_reg_load && sreg_sel == SREG_IRQ_PC) begin
            irq_saved_pc_q <= sreg_wdata; // [R17]
        end else if (system_reg_load && sreg_sel == SREG_IRQ_PSW) begin
            irq_saved_status_q <= sreg_wdata;
        end
    end

    // control transfer to the core
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            jump_q <= 1'b0;
            jump_addr_q <= 32'h0000_0000;
        end else begin
            jump_q <= take_wdt | take_pin | take_irq | take_ill | return_from_trap;
            if (ret_nmi) begin
                jump_addr_q <= nmi_saved_pc_q; // [R10]
            end else if (return_from_trap) begin
                jump_addr_q <= irq_saved_pc_q; // [R20]
            end else if (take_wdt) begin
                jump_addr_q <= NMI_WDT_VEC; // [R9]
            end else if (take_pin) begin
                jump_addr_q <= NMI_PIN_VEC;
            end else if (take_irq) begin
                jump_addr_q <= {16'h0000, irq_code}; // [R1] [R18]
            end else if (take_ill) begin
                jump_addr_q <= ILL_VEC;
            end
        end
    end
endmodule : nic_controller

/* File: src/nic_pkg.sv */
package nic_pkg;
    localparam int NUM_SRC = 55;
    localparam int LVL_W = 3;
    localparam int IDX_W = 6;
    localparam logic [31:0] PSW_RESET = 32'h0000_0020;
    localparam int PSW_NP_BIT = 7;
    localparam int PSW_EP_BIT = 6;
    localparam int PSW_ID_BIT = 5;
    localparam logic [7:0] IC_RESET = 8'h47;
    localparam int IC_FLAG_BIT = 7;
    localparam int IC_MASK_BIT = 6;
    localparam logic [15:0] IRQ_CODE_BASE = 16'h0080;
    localparam logic [15:0] IRQ_CODE_STEP = 16'h0010;
    localparam logic [15:0] NMI_PIN_CODE = 16'h0010;
    localparam logic [15:0] NMI_WDT_CODE = 16'h0020;
    localparam logic [15:0] ILL_CODE = 16'h0060;
    localparam logic [31:0] NMI_PIN_VEC = 32'h0000_0010;
    localparam logic [31:0] NMI_WDT_VEC = 32'h0000_0020;
    localparam logic [31:0] ILL_VEC = 32'h0000_0060;
    localparam logic [31:0] ILL_PC_ADJ = 32'h0000_0004;
    localparam logic [1:0] WDT_NMI_MODE = 2'h1;
    localparam logic [2:0] SREG_PSW = 3'h0;
    localparam logic [2:0] SREG_NMI_PC = 3'h1;
    localparam logic [2:0] SREG_NMI_PSW = 3'h2;
    localparam logic [2:0] SREG_IRQ_PC = 3'h3;
    localparam logic [2:0] SREG_IRQ_PSW = 3'h4;
    typedef enum logic [1:0] {
        NIC_EDGE_OFF = 2'h0,
        NIC_EDGE_RISE = 2'h1,
        NIC_EDGE_FALL = 2'h2,
        NIC_EDGE_BOTH = 2'h3
    } nic_edge_type;
endpackage : nic_pkg

/* File: src/nic_arb_if.sv */
`timescale 1ns/1ns
interface nic_arb_if #(parameter int N = 55);
    logic [N-1:0] req;
    logic [N-1:0] mask;
    logic [N-1:0][2:0] prio;
    logic win_valid;
    logic [5:0] win_idx;
    logic [2:0] win_lvl;
    modport ctl (output req, output mask, output prio, input win_valid, input win_idx, input win_lvl);
    modport arb (input req, input mask, input prio, output win_valid, output win_idx, output win_lvl);
endinterface : nic_arb_if

/* File: src/nic_arbiter.sv */
`timescale 1ns/1ns
module nic_arbiter import nic_pkg::*; #(
    parameter int N = NUM_SRC
) (
    nic_arb_if.arb a
);
    // lowest level wins, lowest index breaks ties
    always_comb begin
        a.win_valid = 1'b0;
        a.win_idx = '0;
        a.win_lvl = '1;
        for (int i = 0; i < N; i++) begin
            if (a.req[i] && !a.mask[i] && (!a.win_valid || a.prio[i] < a.win_lvl)) begin // [R2] [R14]
                a.win_valid = 1'b1;
                a.win_idx = 6'(i);
                a.win_lvl = a.prio[i];
            end
        end
    end
endmodule : nic_arbiter

/* File: src/nic_edge_detect.sv */
`timescale 1ns/1ns
module nic_edge_detect import nic_pkg::*; (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // pin and setting
    input wire logic pin,
    input wire logic [1:0] edge_sel,
    // request
    output logic req_q
);
    logic sync1_q;
    logic sync2_q;
    logic last_q;
    logic rise;
    logic fall;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            sync1_q <= pin; // [R25]
            sync2_q <= sync1_q;
            last_q <= sync2_q;
        end
    end

    assign rise = sync2_q & ~last_q;
    assign fall = ~sync2_q & last_q;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            req_q <= 1'b0;
        end else begin
            case (nic_edge_type'(edge_sel)) // [R5]
                NIC_EDGE_RISE: req_q <= rise;
                NIC_EDGE_FALL: req_q <= fall;
                NIC_EDGE_BOTH: req_q <= rise | fall;
                default: req_q <= 1'b0;
            endcase
        end
    end
endmodule : nic_edge_detect

/* File: testbench/nic_monitor.sv */
`timescale 1ns/1ns
module nic_monitor import nic_pkg::*; #(
    parameter int N = NUM_SRC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // requests and core
    input wire logic watchdog_overflow_nmi,
    input wire logic [1:0] watchdog_mode,
    input wire logic [5:0] ic_addr,
    input wire logic return_from_trap,
    // controller state
    input wire logic [7:0] ic_rdata_q,
    input wire logic jump_q,
    input wire logic [31:0] jump_addr_q,
    input wire logic [31:0] program_status_word_q,
    input wire logic [31:0] nmi_saved_pc_q,
    input wire logic [31:0] nmi_saved_status_q,
    input wire logic [31:0] irq_saved_pc_q,
    input wire logic [31:0] irq_saved_status_q,
    input wire logic [31:0] exception_cause_register_q
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    wire np = program_status_word_q[PSW_NP_BIT];
    wire ep = program_status_word_q[PSW_EP_BIT];
    wire id = program_status_word_q[PSW_ID_BIT];
    wire irq_jmp = jump_q && jump_addr_q >= 32'h0000_0080 && jump_addr_q <= 32'h0000_03e0;
    wire nmi_jmp = jump_q && (jump_addr_q == NMI_PIN_VEC || jump_addr_q == NMI_WDT_VEC);
    // watchdog pulse, then a free cycle for the take
    sequence wdt_take;
        watchdog_overflow_nmi && watchdog_mode == WDT_NMI_MODE ##1 !np && !return_from_trap;
    endsequence
    wdt_entry_a: assert property (wdt_take |=> jump_q && jump_addr_q == NMI_WDT_VEC)
        else $error("watchdog entry missing");
    nmi_state_a: assert property (nmi_jmp && !$past(return_from_trap) |-> np && id && !ep
        && exception_cause_register_q[31:16] == jump_addr_q[15:0]) else $error("bad nmi entry");
    irq_state_a: assert property (irq_jmp && !$past(return_from_trap) |-> id && !ep && !np
        && exception_cause_register_q[15:0] == jump_addr_q[15:0]) else $error("bad irq entry");
    nmi_block_a: assert property (np && !return_from_trap |=> !nmi_jmp)
        else $error("nmi taken while active");
    irq_block_a: assert property ((id || np) && !return_from_trap |=> !irq_jmp)
        else $error("irq taken while blocked");
    nmi_return_a: assert property (return_from_trap && !ep && np |=> jump_q
        && jump_addr_q == $past(nmi_saved_pc_q) && program_status_word_q == $past(nmi_saved_status_q))
        else $error("bad nmi return");
    irq_return_a: assert property (return_from_trap && !ep && !np |=> jump_q
        && jump_addr_q == $past(irq_saved_pc_q) && program_status_word_q == $past(irq_saved_status_q))
        else $error("bad irq return");
    psw_reset_a: assert property ($fell(rst) |-> program_status_word_q == PSW_RESET)
        else $error("bad status reset");
    ic_unmapped_a: assert property (ic_addr >= N |=> ic_rdata_q == 8'h00)
        else $error("unmapped read not zero");
endmodule : nic_monitor

/* File: testbench/nic_core_model.sv */
`timescale 1ns/1ns
module nic_core_model import nic_pkg::*; (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // branch request
    input wire logic jump_q,
    input wire logic [31:0] jump_addr_q,
    // program counter and software reset
    output logic [31:0] cur_pc,
    output logic [31:0] following_pc,
    output logic swrst_q
);
    logic [31:0] pc_q;
    assign cur_pc = pc_q;
    assign following_pc = pc_q + 32'h0000_0004;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pc_q <= 32'h0000_1000;
        end else if (jump_q) begin
            pc_q <= jump_addr_q;
        end else begin
            pc_q <= pc_q + 32'h0000_0004;
        end
    end
    // watchdog service ends in a software reset
    always_ff @(posedge clk_sys) begin
        swrst_q <= !rst && jump_q && jump_addr_q == NMI_WDT_VEC;
    end
endmodule : nic_core_model

/* File: testbench/nic_controller_tb.sv */
`timescale 1ns/1ns
module nic_controller_tb import nic_pkg::*; ;
    logic clk_sys = 1'b0, rst_ext = 1'b1, nmi_pin = 1'b0, wdt = 1'b0, ic_wr = 1'b0, ill = 1'b0;
    logic ret = 1'b0, ei = 1'b0, di = 1'b0, sload = 1'b0, abandon = 1'b0, jump, swrst_q;
    logic [1:0] esel = 2'h0, wmode = 2'h0;
    logic [2:0] ssel = 3'h0;
    logic [5:0] ic_addr = 6'h00;
    logic [7:0] ic_wdata = 8'h00, rdata;
    logic [54:0] irq = 55'h0;
    logic [31:0] sdata = 32'h0000_0000, jaddr, program_status_word, npc, npsw, ipc, ipsw, exception_cause_register, cur_pc, following_pc, fp, cp;
    wire rst = rst_ext || swrst_q;
    int mismatches = 0, n_compared = 0, qk;
    nic_controller i_nic_controller (
        .clk_sys, .rst, .nmi_pin, .nmi_edge_sel(esel), .watchdog_overflow_nmi(wdt), .watchdog_mode(wmode),
        .irq_src(irq), .ic_wr, .ic_addr, .ic_wdata, .ic_rdata_q(rdata), .following_pc, .cur_pc,
        .insn_abandon(abandon), .illegal_op(ill), .return_from_trap(ret), .unmask_all_instruction(ei),
        .mask_all_instruction(di), .system_reg_load(sload), .sreg_sel(ssel), .sreg_wdata(sdata),
        .jump_q(jump), .jump_addr_q(jaddr), .program_status_word_q(program_status_word), .nmi_saved_pc_q(npc),
        .nmi_saved_status_q(npsw), .irq_saved_pc_q(ipc), .irq_saved_status_q(ipsw),
        .exception_cause_register_q(exception_cause_register)
    );
    nic_core_model i_nic_core_model (
        .clk_sys, .rst, .jump_q(jump), .jump_addr_q(jaddr), .cur_pc, .following_pc, .swrst_q
    );
    always #25 clk_sys = ~clk_sys;
    task automatic results();
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : tick
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask : pulse
    task automatic fire(input logic [54:0] v);
        irq = v;
        tick(1);
        irq = 55'h0;
    endtask : fire
    task automatic do_reset();
        rst_ext = 1'b1;
        tick(20);
        rst_ext = 1'b0;
    endtask : do_reset
    // waits for a branch, keeping the pc values of the deciding cycle
    task automatic wjump();
        for (int i = 0; i < 20; i++) begin
            if (jump === 1'b1) break;
            fp = following_pc;
            cp = cur_pc;
            tick(1);
        end
        chk(jump, 1'b1);
    endtask : wjump
    task automatic quiet(input int n);
        qk = 0;
        repeat (n) begin
            tick(1);
            if (jump !== 1'b0) qk++;
        end
    endtask : quiet
    task automatic wic(input logic [5:0] a, input logic [7:0] d);
        ic_addr = a;
        ic_wdata = d;
        pulse(ic_wr);
        tick(1);
    endtask : wic
    task automatic ric(input logic [5:0] a);
        ic_addr = a;
        tick(1);
    endtask : ric
    task automatic t_reset();
        chk(program_status_word, PSW_RESET);
        ric(6'h00);
        chk(rdata, IC_RESET);
        ric(6'h37);
        chk(rdata, 8'h00);
        $display("done reset values");
    endtask : t_reset
    task automatic t_irq_order();
        logic [31:0] r;
        pulse(ei);
        wic(6'h32, 8'h07);
        wic(6'h35, 8'h07);
        fire((55'h1 << 50) | (55'h1 << 53));
        wjump();
        r = fp;
        chk(jaddr, 32'h0000_03a0);
        chk(exception_cause_register[15:0], 16'h03a0);
        chk(ipc, r);
        chk(ipsw, 32'h0000_0000);
        chk(program_status_word[PSW_ID_BIT], 1'b1);
        ric(6'h32);
        chk(rdata, 8'h07);
        ric(6'h35);
        chk(rdata, 8'h87);
        pulse(ret);
        wjump();
        chk(jaddr, r);
        chk(program_status_word, 32'h0000_0000);
        tick(1);
        wjump();
        chk(jaddr, 32'h0000_03d0);
        $display("done default order");
    endtask : t_irq_order
    task automatic t_prio();
        do_reset();
        pulse(ei);
        wic(6'h30, 8'h05);
        wic(6'h36, 8'h02);
        wic(6'h31, 8'h42);
        abandon = 1'b1;
        fire((55'h1 << 48) | (55'h1 << 49) | (55'h1 << 54));
        wjump();
        abandon = 1'b0;
        chk(jaddr, 32'h0000_03e0);
        chk(ipc, cp);
        pulse(ei);
        wic(6'h31, 8'h82);
        quiet(6);
        chk(qk, 0);
        wic(6'h33, 8'h01);
        fire(55'h1 << 51);
        wjump();
        chk(jaddr, 32'h0000_03b0);
        $display("done programmed levels");
    endtask : t_prio
    task automatic t_wdt();
        do_reset();
        wmode = 2'h2;
        pulse(wdt);
        quiet(6);
        chk(qk, 0);
        wmode = WDT_NMI_MODE;
        pulse(wdt);
        wjump();
        chk(jaddr, NMI_WDT_VEC);
        chk(exception_cause_register[31:16], NMI_WDT_CODE);
        chk(program_status_word[7:5], 3'h5);
        chk(npc, fp);
        chk(npsw, PSW_RESET);
        tick(3);
        chk(program_status_word, PSW_RESET);
        $display("done watchdog");
    endtask : t_wdt
    task automatic t_pin();
        for (int s = 0; s < 4; s++) begin
            do_reset();
            esel = s[1:0];
            nmi_pin = 1'b1;
            quiet(10);
            chk(qk, s % 2);
            ret = 1'b1;
            nmi_pin = 1'b0;
            tick(1);
            ret = 1'b0;
            quiet(10);
            chk(qk, s / 2);
        end
        nmi_pin = 1'b1;
        quiet(10);
        chk(qk, 0);
        pulse(ret);
        wjump();
        tick(1);
        wjump();
        chk(jaddr, NMI_PIN_VEC);
        pulse(wdt);
        quiet(6);
        chk(qk, 0);
        ssel = SREG_PSW;
        sdata = PSW_RESET;
        pulse(sload);
        wjump();
        chk(jaddr, NMI_WDT_VEC);
        nmi_pin = 1'b0;
        tick(3);
        $display("done pin edges");
    endtask : t_pin
    task automatic t_ill();
        cp = cur_pc;
        pulse(ill);
        wjump();
        chk(jaddr, ILL_VEC);
        chk(ipc, cp + ILL_PC_ADJ);
        $display("done illegal opcode");
    endtask : t_ill
    task automatic wsr(input logic [2:0] sel, input logic [31:0] d);
        ssel = sel;
        sdata = d;
        sload = 1'b1;
        tick(1);
    endtask : wsr
    task automatic t_sreg();
        pulse(ei);
        pulse(di);
        chk(program_status_word[PSW_ID_BIT], 1'b1);
        wsr(SREG_IRQ_PC, 32'h0000_2000);
        wsr(SREG_IRQ_PSW, 32'h0000_0000);
        wsr(SREG_NMI_PC, 32'h0000_3000);
        wsr(SREG_NMI_PSW, PSW_RESET);
        sload = 1'b0;
        chk(ipc, 32'h0000_2000);
        chk(ipsw, 32'h0000_0000);
        chk(npc, 32'h0000_3000);
        chk(npsw, PSW_RESET);
        pulse(ret);
        wjump();
        chk(jaddr, 32'h0000_2000);
        chk(program_status_word, 32'h0000_0000);
        nmi_pin = 1'b1;
        tick(3);
        pulse(wdt);
        wjump();
        chk(jaddr, NMI_WDT_VEC);
        nmi_pin = 1'b0;
        tick(3);
        $display("done system registers");
    endtask : t_sreg
    initial begin
        do_reset();
        t_reset();
        t_irq_order();
        t_prio();
        t_wdt();
        t_pin();
        t_ill();
        t_sreg();
        results();
    end
    initial begin
        repeat (5000) @(posedge clk_sys);
        mismatches++;
        results();
    end
endmodule : nic_controller_tb
bind nic_controller nic_monitor #(.N(N)) i_nic_monitor (
    .clk_sys, .rst, .watchdog_overflow_nmi, .watchdog_mode, .ic_addr, .return_from_trap, .ic_rdata_q,
    .jump_q, .jump_addr_q, .program_status_word_q, .nmi_saved_pc_q, .nmi_saved_status_q,
    .irq_saved_pc_q, .irq_saved_status_q, .exception_cause_register_q
);
